// >>> rtl/pressure_sample_fifo_regs.svh
// register offsets, field positions and timing counts for the pressure sample buffer
// assumes inclusion from the buffer module only
`ifndef PRESSURE_SAMPLE_FIFO_REGS_SVH
`define PRESSURE_SAMPLE_FIFO_REGS_SVH
`define ADDR_CONTROL_TWO      7'h21
`define ADDR_CONTROL_FOUR     7'h23
`define ADDR_INTERRUPT_CFG    7'h24
`define ADDR_PRESS_XLOW       7'h28
`define ADDR_PRESS_LOW        7'h29
`define ADDR_PRESS_HIGH       7'h2a
`define ADDR_BUFFER_CONTROL   7'h2e
`define ADDR_BUFFER_STATUS    7'h2f
// control_two fields
`define CT2_BUF_ENABLE_BIT    6
`define CT2_STOP_THRESH_BIT   5
`define CT2_AVG_DECIMATE_BIT  4
// control_four fields
`define CT4_OVERRUN_INT_BIT   3
`define CT4_WATERMARK_INT_BIT 2
// buffer_control fields
`define BC_MODE_MSB           7
`define BC_MODE_LSB           5
`define BC_WTM_MSB            4
`define BC_WTM_LSB            0
// buffer_status fields
`define BS_THRESH_BIT         7
`define BS_OVERRUN_BIT        6
`define BS_EMPTY_BIT          5
// reset values
`define RST_BYTE              8'h00
// sample depth
`define SLOT_COUNT            32
// decimated output periods (sample counts) per rate code
`define DEC_PERIOD_RATE2      6'd07
`define DEC_PERIOD_RATE3      6'd12
`define DEC_PERIOD_RATE4      6'd25
`endif

// >>> rtl/pressure_sample_fifo_pkg.sv
// types for the pressure sample buffer
// assumes the constants header sits beside it
package pressure_sample_fifo_pkg;
    typedef enum logic [2:0] {
        MODE_BYPASS, MODE_FIFO, MODE_STREAM, MODE_STREAM_TO_FIFO,
        MODE_BYPASS_TO_STREAM, MODE_RSVD5, MODE_MEAN, MODE_BYPASS_TO_FIFO
    } buf_mode_e;
    typedef enum logic [1:0] {BEH_IDLE, BEH_FILL, BEH_STREAM} buf_beh_e;
    typedef logic [23:0] sample_t;
endpackage

// >>> rtl/pressure_sample_fifo.sv
// 32-slot pressure sample buffer with register port and averaging
// assumes a register port on sys_clk: one-cycle rd/wr strobes, 7-bit address
// assumes samples and trigger arrive as one-cycle strobes from on-chip logic
`timescale 1ns/1ps
`include "pressure_sample_fifo_regs.svh"
module pressure_sample_fifo (
    input  wire logic                            sys_clk,
    input  wire logic                            rstn,
    input  wire pressure_sample_fifo_pkg::sample_t sample_data,
    input  wire logic                            sample_valid,
    input  wire logic                            trigger_event,
    input  wire logic [1:0]                      output_rate,
    input  wire logic [6:0]                      reg_addr,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    input  wire logic [7:0]                      reg_wdata,
    output logic      [7:0]                      reg_rdata,
    output logic                                 interrupt_pin
);
    import pressure_sample_fifo_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // storage and state
    sample_t        mem_r [`SLOT_COUNT];
    logic [4:0]     wr_ptr_r;
    logic [4:0]     rd_ptr_r;
    logic [5:0]     count_r;
    logic           overrun_r;
    logic           triggered_r;
    logic [7:0]     control_two_r;
    logic [7:0]     control_four_r;
    logic [7:0]     interrupt_cfg_r;
    logic [7:0]     buffer_control_r;
    sample_t        out_r;
    logic [29:0]    avg_sum_r;
    logic [29:0]    avg_sum_nxt;
    logic [5:0]     dec_cnt_r;
    buf_mode_e      mode;
    buf_beh_e       beh;
    logic           enabled;
    logic           full;
    logic           do_push;
    logic           do_pop;
    logic           do_drop;
    logic [5:0]     avg_len;
    logic [5:0]     thresh_lvl;
    logic           thresh_hit;

    // average length: watermark field plus one
    function automatic logic [5:0] len_of(input logic [4:0] wtm);
        len_of = {1'b0, wtm} + 6'd1;
    endfunction

    // 24-bit average of the window sum, power-of-two lengths only
    function automatic sample_t avg_of(input logic [29:0] s, input logic [4:0] wtm);
        case (wtm)
            5'h01:   avg_of = s[24:1];
            5'h03:   avg_of = s[25:2];
            5'h07:   avg_of = s[26:3];
            5'h0f:   avg_of = s[27:4];
            5'h1f:   avg_of = s[28:5];
            default: avg_of = s[23:0];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // mode decode; trigger-mode switches keep occupancy untouched
    always_comb begin
        mode    = buf_mode_e'(buffer_control_r[`BC_MODE_MSB:`BC_MODE_LSB]);
        enabled = control_two_r[`CT2_BUF_ENABLE_BIT];
        case (mode)
            MODE_FIFO:             beh = BEH_FILL;
            MODE_STREAM:           beh = BEH_STREAM;
            MODE_MEAN:             beh = BEH_STREAM;
            MODE_STREAM_TO_FIFO:   beh = triggered_r ? BEH_FILL : BEH_STREAM;
            MODE_BYPASS_TO_STREAM: beh = triggered_r ? BEH_STREAM : BEH_IDLE;
            MODE_BYPASS_TO_FIFO:   beh = triggered_r ? BEH_FILL : BEH_IDLE;
            default:               beh = BEH_IDLE;
        endcase
        if (!enabled)
            beh = BEH_IDLE;
        full       = (count_r == 6'(`SLOT_COUNT));
        avg_len    = len_of(buffer_control_r[`BC_WTM_MSB:`BC_WTM_LSB]);
        thresh_lvl = {1'b0, buffer_control_r[`BC_WTM_MSB:`BC_WTM_LSB]};
        thresh_hit = (thresh_lvl != 6'd0) && (count_r >= thresh_lvl);
        // mean mode keeps a window of avg_len, so it drops once that is reached
        do_push = sample_valid && (beh != BEH_IDLE) && !(beh == BEH_FILL && full);
        do_drop = sample_valid && (beh == BEH_STREAM) &&
                  (mode == MODE_MEAN ? count_r >= avg_len : full);
        // a read of the high byte advances; the xlow read loads the output
        do_pop  = reg_rd && (reg_addr == `ADDR_PRESS_HIGH) && enabled && mode != MODE_MEAN
                  && count_r != 6'd0 && !do_drop;

        // window sum after this cycle's sample: add the new one, take out the dropped oldest
        avg_sum_nxt = avg_sum_r + {6'd0, sample_data}
                      - (do_drop ? {6'd0, mem_r[rd_ptr_r]} : 30'd0);
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            control_two_r    <= `RST_BYTE;
            control_four_r   <= `RST_BYTE;
            interrupt_cfg_r  <= `RST_BYTE;
            buffer_control_r <= `RST_BYTE;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_CONTROL_TWO:    control_two_r    <= reg_wdata;
                `ADDR_CONTROL_FOUR:   control_four_r   <= reg_wdata;
                `ADDR_INTERRUPT_CFG:  interrupt_cfg_r  <= reg_wdata;
                `ADDR_BUFFER_CONTROL: buffer_control_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trigger latch; cleared when mode or enable is rewritten
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            triggered_r <= 1'b0;
        else if (trigger_event)
            triggered_r <= 1'b1;
        else if (reg_wr && (reg_addr == `ADDR_BUFFER_CONTROL || reg_addr == `ADDR_CONTROL_TWO))
            triggered_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // sample storage; array has no reset on purpose, pointers guard it
    always_ff @(posedge sys_clk) begin
        if (do_push)
            mem_r[wr_ptr_r] <= sample_data;
    end

    // pointers and occupancy
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_r <= 5'd0;
            rd_ptr_r <= 5'd0;
            count_r  <= 6'd0;
        end else if (beh == BEH_IDLE && !triggered_r) begin
            wr_ptr_r <= 5'd0;
            rd_ptr_r <= 5'd0;
            count_r  <= 6'd0;
        end else begin
            if (do_push)
                wr_ptr_r <= wr_ptr_r + 5'd1;
            if (do_pop || do_drop)
                rd_ptr_r <= rd_ptr_r + 5'd1;
            case ({do_push && !do_drop, do_pop})
                2'b10:   count_r <= count_r + 6'd1;
                2'b01:   count_r <= count_r - 6'd1;
                default: count_r <= count_r;
            endcase
        end
    end

    // overrun: set by a sample while full outside mean mode, cleared once the buffer is no longer full
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            overrun_r <= 1'b0;
        else if (sample_valid && full && beh != BEH_IDLE && mode != MODE_MEAN)
            overrun_r <= 1'b1;
        else if (!full)
            overrun_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // running window sum: add new, subtract dropped oldest
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            avg_sum_r <= 30'd0;
        else if (mode != MODE_MEAN || beh == BEH_IDLE)
            avg_sum_r <= 30'd0;
        else if (sample_valid)
            avg_sum_r <= avg_sum_nxt;
    end

    // decimation counter in sample periods per rate code
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            dec_cnt_r <= 6'd0;
        else if (sample_valid && mode == MODE_MEAN)
            dec_cnt_r <= (dec_cnt_r == 6'd0) ? (output_rate == 2'd3 ? `DEC_PERIOD_RATE3 :
                         output_rate == 2'd2 ? `DEC_PERIOD_RATE2 : `DEC_PERIOD_RATE4) - 6'd1
                         : dec_cnt_r - 6'd1;
    end

    ////////////////////////////////////////////////////////////////////////
    // pressure output holding register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            out_r <= '0;
        else if (mode == MODE_MEAN && enabled) begin
            // the post-sample sum feeds the output, so the newest sample counts at once
            if (sample_valid && (!control_two_r[`CT2_AVG_DECIMATE_BIT] || dec_cnt_r == 6'd0))
                out_r <= avg_of(avg_sum_nxt, buffer_control_r[`BC_WTM_MSB:`BC_WTM_LSB]);
        end else if (!enabled) begin
            if (sample_valid)
                out_r <= sample_data;
        end else if (reg_rd && reg_addr == `ADDR_PRESS_XLOW && count_r != 6'd0)
            out_r <= mem_r[rd_ptr_r];
    end

    ////////////////////////////////////////////////////////////////////////
    // read data; byte mux registered one cycle after strobe
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (reg_rd) begin
            case (reg_addr)
                `ADDR_CONTROL_TWO:    reg_rdata <= control_two_r;
                `ADDR_CONTROL_FOUR:   reg_rdata <= control_four_r;
                `ADDR_INTERRUPT_CFG:  reg_rdata <= interrupt_cfg_r;
                // xlow read serves the freshly loaded oldest entry
                `ADDR_PRESS_XLOW:     reg_rdata <= (enabled && mode != MODE_MEAN && count_r != 6'd0)
                                                   ? mem_r[rd_ptr_r][7:0] : out_r[7:0];
                `ADDR_PRESS_LOW:      reg_rdata <= out_r[15:8];
                `ADDR_PRESS_HIGH:     reg_rdata <= out_r[23:16];
                `ADDR_BUFFER_CONTROL: reg_rdata <= buffer_control_r;
                `ADDR_BUFFER_STATUS:  reg_rdata <= {thresh_hit, overrun_r,
                                                    count_r == 6'd0, count_r[4:0]};
                default:              reg_rdata <= 8'h00;
            endcase
        end
    end

    // interrupt routing
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            interrupt_pin <= 1'b0;
        else
            interrupt_pin <= (control_four_r[`CT4_WATERMARK_INT_BIT] &&
                              control_two_r[`CT2_STOP_THRESH_BIT] && thresh_hit) ||
                             (control_four_r[`CT4_OVERRUN_INT_BIT] && overrun_r);
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    // occupancy bounds and full behaviour
    a_count_bound: assert property (@(posedge sys_clk) disable iff (!rstn)
        count_r <= 6'd32) else $error("occupancy above 32");

    a_bypass_empty: assert property (@(posedge sys_clk) disable iff (!rstn)
        (mode == MODE_BYPASS && enabled) |=> count_r == 6'd0) else $error("bypass not empty");

    a_fill_stops: assert property (@(posedge sys_clk) disable iff (!rstn)
        (beh == BEH_FILL && full && !do_pop) |=> full) else $error("fill mode left full");

    // a refused sample must not move the write side
    a_fill_refuse: assert property (@(posedge sys_clk) disable iff (!rstn)
        (beh == BEH_FILL && full && sample_valid) |=> $stable(wr_ptr_r))
        else $error("full buffer took a sample");

    a_stream_full: assert property (@(posedge sys_clk) disable iff (!rstn)
        (beh == BEH_STREAM && mode != MODE_MEAN && full && sample_valid && !do_pop) |=> full)
        else $error("stream lost fullness");

    // gating by enable, mode and trigger
    a_off_empty: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!enabled && !triggered_r) |=> count_r == 6'd0) else $error("disabled buffer not empty");

    a_wait_stream: assert property (@(posedge sys_clk) disable iff (!rstn)
        (mode == MODE_BYPASS_TO_STREAM && !triggered_r) |=> count_r == 6'd0)
        else $error("stream started before trigger");

    a_idle_trig: assert property (@(posedge sys_clk) disable iff (!rstn)
        (mode == MODE_BYPASS_TO_FIFO && !triggered_r) |-> !do_push)
        else $error("stored before trigger");

    a_mean_nopop: assert property (@(posedge sys_clk) disable iff (!rstn)
        (mode == MODE_MEAN) |-> !do_pop) else $error("mean mode popped");

    // overrun in both refusing and discarding behaviour
    a_overrun_set: assert property (@(posedge sys_clk) disable iff (!rstn)
        (sample_valid && full && beh == BEH_FILL) |=> overrun_r) else $error("overrun missed");

    a_overrun_stream: assert property (@(posedge sys_clk) disable iff (!rstn)
        (sample_valid && full && beh == BEH_STREAM && mode != MODE_MEAN) |=> overrun_r)
        else $error("stream overrun missed");

    // interrupt routing, watermark judged from the raw fields
    a_wtm_irq: assert property (@(posedge sys_clk) disable iff (!rstn)
        (control_two_r[`CT2_STOP_THRESH_BIT] && control_four_r[`CT4_WATERMARK_INT_BIT] &&
         buffer_control_r[`BC_WTM_MSB:`BC_WTM_LSB] != 5'd0 &&
         count_r >= {1'b0, buffer_control_r[`BC_WTM_MSB:`BC_WTM_LSB]}) |=> interrupt_pin)
        else $error("watermark interrupt missing");

    a_ovr_irq: assert property (@(posedge sys_clk) disable iff (!rstn)
        (control_four_r[`CT4_OVERRUN_INT_BIT] && overrun_r) |=> interrupt_pin)
        else $error("overrun interrupt missing");

    a_irq_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!control_four_r[`CT4_WATERMARK_INT_BIT] && !control_four_r[`CT4_OVERRUN_INT_BIT])
        |=> !interrupt_pin) else $error("interrupt without route");
endmodule

// >>> sim/host_model.sv
// host side model: reads and writes the buffer's registers over its strobe port
// assumes reg_rdata is registered and valid one cycle after the read strobe
`timescale 1ns/1ps
module host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [6:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata
);
    // idle values before the first request
    initial begin
        reg_addr = 7'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one-cycle write strobe; data inverted on release so stale bytes never pass
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // read data taken once the strobe edge has updated it
    task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // xlow read loads the oldest entry; host walks the three bytes up to the high one, which advances
    task automatic rd_sample(output logic [23:0] s);
        logic [7:0] b;
        for (int i = 0; i < 3; i++) begin
            rd_reg(7'h28 + 7'(i), b);
            s[8*i +: 8] = b;
        end
    endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the pressure sample buffer
// assumes host_model and the design are compiled ahead of it
`timescale 1ns/1ps
module tb_top;
    import pressure_sample_fifo_pkg::*;
    logic       sys_clk;
    logic       rstn;
    sample_t    sample_data;
    logic       sample_valid;
    logic       trigger_event;
    logic [1:0] output_rate;
    logic [6:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       interrupt_pin;
    int         fails;
    int         checks_done;
    int         n;
    logic [7:0] b;
    sample_t    s;
    logic [6:0] ra [4] = '{7'h21, 7'h23, 7'h24, 7'h2e};
    buf_mode_e  tm [6] = '{MODE_FIFO, MODE_STREAM, MODE_STREAM_TO_FIFO,
                           MODE_BYPASS_TO_STREAM, MODE_BYPASS_TO_FIFO, MODE_BYPASS};
    int         tpre [6] = '{33, 34, 34, 3, 3, 5};
    int         ttrig [6] = '{0, 0, 1, 1, 1, 0};
    int         tpost [6] = '{0, 0, 1, 34, 33, 0};
    int         tfirst [6] = '{0, 2, 2, 5, 3, 0};

    pressure_sample_fifo pressure_sample_fifo_i (.sys_clk(sys_clk), .rstn(rstn),
        .sample_data(sample_data), .sample_valid(sample_valid),
        .trigger_event(trigger_event), .output_rate(output_rate), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .interrupt_pin(interrupt_pin));
    host_model host_model_i (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    // 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // compares, one per kind of result
    task automatic chk_byte(input string w, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk_sample(input string w, input sample_t e, input sample_t g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk_bit(input string w, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", w, e, g);
        end
    endtask
    // bytes all differ so a swapped byte lane shows up
    function automatic sample_t sample_of(input int i);
        return {8'h5a ^ i[7:0], i[7:0], ~i[7:0]};
    endfunction
    // one-cycle sample strobe
    task automatic push(input sample_t v);
        @(posedge sys_clk);
        sample_data <= v;
        sample_valid <= 1'b1;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
    endtask
    task automatic pulse_trigger();
        @(posedge sys_clk);
        trigger_event <= 1'b1;
        @(posedge sys_clk);
        trigger_event <= 1'b0;
    endtask
    // passing through bypass empties the buffer and clears the trigger latch
    task automatic set_mode(input buf_mode_e m, input logic [4:0] wm);
        host_model_i.wr_reg(7'h2e, 8'h00);
        host_model_i.wr_reg(7'h2e, {m, wm});
    endtask
    task automatic report_and_stop();
        if (fails == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog, well beyond the roughly 1,800 cycles the tests need
    initial begin
        #200_000;
        fails++;
        report_and_stop();
    end
    // main sequence
    initial begin
        rstn = 1'b0;
        sample_data = 24'h00_0000;
        sample_valid = 1'b0;
        trigger_event = 1'b0;
        output_rate = 2'd2;
        fails = 0;
        checks_done = 0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            host_model_i.rd_reg(ra[i], b);
            chk_byte("reset value", 8'h00, b);
        end
        host_model_i.rd_reg(7'h2f, b);
        chk_byte("reset status", 8'h20, b);
        host_model_i.wr_reg(7'h30, 8'h5a);
        host_model_i.rd_reg(7'h30, b);
        chk_byte("unmapped", 8'h00, b);
        host_model_i.wr_reg(7'h21, 8'h40);
        // every mode but mean and the reserved one, oldest sample tracked through fills, drops and triggers
        for (int t = 0; t < 6; t++) begin
            set_mode(tm[t], 5'd0);
            n = 0;
            repeat (tpre[t]) begin push(sample_of(n)); n++; end
            if (ttrig[t] == 1) pulse_trigger();
            repeat (tpost[t]) begin push(sample_of(n)); n++; end
            host_model_i.rd_reg(7'h2f, b);
            chk_byte("status", (tm[t] == MODE_BYPASS) ? 8'h20 : 8'h40, b);
            for (int i = 0; i < ((tm[t] == MODE_BYPASS) ? 0 : 32); i++) begin
                host_model_i.rd_sample(s);
                chk_sample("oldest", sample_of(tfirst[t] + i), s);
            end
            host_model_i.rd_reg(7'h2f, b);
            chk_byte("drained", 8'h20, b);
        end
        // running average over every power-of-two length, 2 to 32, window then slides by one
        for (int l = 2; l <= 32; l = l * 2) begin
            set_mode(MODE_MEAN, 5'(l - 1));
            for (int i = 0; i < l; i++) push(24'(16 * i));
            host_model_i.rd_sample(s);
            chk_sample("mean", 24'(8 * (l - 1)), s);
            push(24'(16 * l));
            repeat (2) begin
                host_model_i.rd_sample(s);
                chk_sample("mean slid", 24'(8 * (l + 1)), s);
            end
        end
        // watermark crossing in both directions, routed to the pin
        host_model_i.wr_reg(7'h21, 8'h60);
        host_model_i.wr_reg(7'h23, 8'h04);
        set_mode(MODE_FIFO, 5'd4);
        repeat (3) push(sample_of(0));
        host_model_i.rd_reg(7'h2f, b);
        chk_byte("below mark", 8'h03, b);
        chk_bit("pin low", 1'b0, interrupt_pin);
        push(sample_of(0));
        host_model_i.rd_reg(7'h2f, b);
        chk_byte("at mark", 8'h84, b);
        chk_bit("pin high", 1'b1, interrupt_pin);
        host_model_i.rd_sample(s);
        host_model_i.rd_reg(7'h2f, b);
        chk_byte("after pop", 8'h03, b);
        chk_bit("pin drop", 1'b0, interrupt_pin);
        // overrun routed to the pin once a full buffer refuses a sample
        host_model_i.wr_reg(7'h23, 8'h08);
        set_mode(MODE_FIFO, 5'd0);
        repeat (33) push(sample_of(0));
        host_model_i.rd_reg(7'h2f, b);
        chk_byte("overrun status", 8'h40, b);
        chk_bit("overrun pin", 1'b1, interrupt_pin);
        // reset in mid-run clears controls and the pin, and restarts decimation
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        host_model_i.rd_reg(7'h21, b);
        chk_byte("control after reset", 8'h00, b);
        chk_bit("pin after reset", 1'b0, interrupt_pin);
        // decimated average at rate code 2: first sample posts, then every seventh
        host_model_i.wr_reg(7'h21, 8'h50);
        set_mode(MODE_MEAN, 5'd1);
        repeat (7) push(24'h00_0010);
        host_model_i.rd_sample(s);
        chk_sample("decimated hold", 24'h00_0008, s);
        push(24'h00_0010);
        host_model_i.rd_sample(s);
        chk_sample("decimated update", 24'h00_0010, s);
        report_and_stop();
    end
endmodule
